// *** fpex_regs.vh ***
// fpex_regs.vh: register offsets, field layouts and codes for the FP exception unit
// assumes inclusion by bare name from the design file
`ifndef FPEX_REGS_VH
`define FPEX_REGS_VH
// register indices on the plain port (byte address = index * 4)
`define FPEX_ADDR_CSR 4'h0
`define FPEX_ADDR_STAT 4'h1
`define FPEX_ADDR_RES_LO 4'h2
`define FPEX_ADDR_RES_HI 4'h3
// control/status field positions
`define FPEX_RND_LO 1
`define FPEX_RND_HI 0
`define FPEX_FLAG_LO 2
`define FPEX_FLAG_HI 6
`define FPEX_EN_LO 7
`define FPEX_EN_HI 11
`define FPEX_CAUSE_LO 12
`define FPEX_CAUSE_HI 17
`define FPEX_FLUSH_BIT 24
`define FPEX_CSR_MASK 32'h0103FFFF
`define FPEX_CSR_RESET 32'h00000000
// exception bit order inside cause/enable/flag: I U O Z V, with E in cause only
`define FPEX_I 0
`define FPEX_U 1
`define FPEX_O 2
`define FPEX_Z 3
`define FPEX_V 4
`define FPEX_E 5
// rounding modes
`define FPEX_RN 2'h0
`define FPEX_RZ 2'h1
`define FPEX_RP 2'h2
`define FPEX_RMI 2'h3
// operation classes from the datapath
`define FPEX_OP_ADD 4'h0
`define FPEX_OP_SUB 4'h1
`define FPEX_OP_MUL 4'h2
`define FPEX_OP_DIV 4'h3
`define FPEX_OP_SQRT 4'h4
`define FPEX_OP_MAG 4'h5
`define FPEX_OP_SIGN 4'h6
`define FPEX_OP_COPY 4'h7
`define FPEX_OP_CMP 4'h8
`define FPEX_OP_CVT 4'h9
`define FPEX_OP_MOVE 4'hA
// floating-point exception code for the core's cause register
`define FPEX_EXC_CODE 5'h0F
// double-format constants
`define FPEX_QNAN_D 64'h7FF7FFFFFFFFFFFF
`define FPEX_INF_D 64'h7FF0000000000000
`define FPEX_MAXF_D 64'h7FEFFFFFFFFFFFFF
`define FPEX_MINN_D 64'h0010000000000000
`define FPEX_ZERO_D 64'h0000000000000000
`define FPEX_SIGN_D 63
`endif

// *** fpex_exception_logic.v ***
// fpex_exception_logic.v: FP exception detection, trap versus substitute
// result selection, cause/enable/flag register and its software port.
// assumes the datapath presents one operation per op_valid pulse with
// operand class bits and an unbounded-exponent rounded result summary.
//
// Overview of operation
// - each standard type's enable chooses between trapping and setting a flag
// - on a trap the destination write is suppressed, sources untouched
// - untrapped exceptions write the defined substitute result and continue
// - inexact, underflow, overflow, divide-by-zero, invalid each have cause/enable/flag
// - unimplemented operation has a cause bit only and always traps
// - trap reports the FP exception code; cause bits hold the reason
// - a flag is set to one when its exception occurs without a trap
// - inexact on inexact rounding, overflow, or flushed underflow
// - invalid on inf-inf, zero times inf, 0/0, inf/inf, unordered compare, negative sqrt
// - signalling NaN to arithmetic, compare or convert is invalid; copy is exempt
// - untrapped invalid delivers a quiet NaN
// - finite nonzero divided by zero is divide-by-zero; delivers signed infinity
// - overflow also raises inexact; substitute follows rounding mode and sign
// - tininess is judged after rounding, strictly inside the minimum normal
// - underflow loss of accuracy is judged as an inexact result
// - underflow with either enable set or flush clear traps unimplemented
// - flushed underflow delivers a result by rounding mode and sign
// - reserved operation or format codes set unimplemented and trap
// - denormal or quiet NaN operands (except to compares), bad formats, invalid conversions are unimplemented
// - operand traps apply only to convert and computational instructions
// - writing zero to the cause field clears all pending exceptions
// - overflow or underflow with inexact sets both bits, no priority
// - rounding field 0 nearest, 1 zero, 2 plus infinity, 3 minus infinity
// - the hardware sets no flag bits when a trap is taken
// - control register access through the port needs no hazard wait
`timescale 1ns/10ps
`include "fpex_regs.vh"

module fpex_exception_logic (
  input wire clk_sys,
  input wire rst_n,
  // software port (move_to_fpu_control / move_from_fpu_control)
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // operation summary from the datapath
  input wire op_valid,
  input wire [3:0] op_class,
  input wire op_reserved,
  input wire op_bad_format,
  input wire op_cmp_ordered,
  input wire a_zero,
  input wire a_inf,
  input wire a_snan,
  input wire a_qnan,
  input wire a_denorm,
  input wire a_neg,
  input wire b_zero,
  input wire b_inf,
  input wire b_snan,
  input wire b_qnan,
  input wire b_denorm,
  input wire b_neg,
  input wire eff_subtract,
  input wire res_sign,
  input wire res_inexact,
  input wire res_overflow,
  input wire res_tiny,
  input wire [63:0] res_value,
  // towards the register file and the core
  output reg dest_we,
  output reg [63:0] dest_value,
  output reg trap,
  output reg [4:0] trap_code,
  output reg [5:0] trap_cause
);

  reg [31:0] csr;
  reg [63:0] last_result;

  wire [1:0] rnd = csr[`FPEX_RND_LO:`FPEX_RND_HI];
  wire [4:0] enables = csr[`FPEX_EN_HI:`FPEX_EN_LO];
  wire flush_select = csr[`FPEX_FLUSH_BIT];

  // overflow/underflow substitute by rounding mode and sign
  function [63:0] fpex_round_sub;
    input [1:0] mode;
    input sgn;
    input big;
    reg [63:0] up;
    reg [63:0] down;
    begin
      up = big ? `FPEX_INF_D : `FPEX_MINN_D;
      down = big ? `FPEX_MAXF_D : `FPEX_ZERO_D;
      case (mode)
        `FPEX_RN: fpex_round_sub = up;
        `FPEX_RZ: fpex_round_sub = down;
        `FPEX_RP: fpex_round_sub = sgn ? down : up;
        `FPEX_RMI: fpex_round_sub = sgn ? up : down;
        default: fpex_round_sub = down;
      endcase
      fpex_round_sub[`FPEX_SIGN_D] = sgn;
    end
  endfunction

  // classification of the current operation
  wire is_copy = (op_class == `FPEX_OP_COPY);
  wire is_move = (op_class == `FPEX_OP_MOVE);
  wire is_cmp = (op_class == `FPEX_OP_CMP);
  wire is_two = (op_class == `FPEX_OP_ADD) || (op_class == `FPEX_OP_SUB) ||
    (op_class == `FPEX_OP_MUL) || (op_class == `FPEX_OP_DIV) || is_cmp;
  // operand traps only for convert and computational ops, never moves
  wire operand_op = !is_move && !is_copy;
  wire any_snan = a_snan || (is_two && b_snan);
  wire any_qnan = a_qnan || (is_two && b_qnan);
  wire any_denorm = a_denorm || (is_two && b_denorm);

  reg [5:0] det;
  reg next_trap;
  reg [63:0] next_value;
  wire addsub = (op_class == `FPEX_OP_ADD) || (op_class == `FPEX_OP_SUB);
  wire arith_res = !is_cmp && !is_copy && !is_move;

  always @* begin
    det = 6'h00;
    // invalid operation
    if (addsub && eff_subtract && a_inf && b_inf)
      det[`FPEX_V] = 1'b1;
    if ((op_class == `FPEX_OP_MUL) && ((a_zero && b_inf) || (a_inf && b_zero)))
      det[`FPEX_V] = 1'b1;
    if ((op_class == `FPEX_OP_DIV) && ((a_zero && b_zero) || (a_inf && b_inf)))
      det[`FPEX_V] = 1'b1;
    if (is_cmp && op_cmp_ordered && (any_snan || any_qnan))
      det[`FPEX_V] = 1'b1;
    if ((op_class == `FPEX_OP_SQRT) && a_neg && !a_zero && !a_qnan)
      det[`FPEX_V] = 1'b1;
    if (operand_op && any_snan)
      det[`FPEX_V] = 1'b1;
    // divide by zero: finite nonzero dividend
    if ((op_class == `FPEX_OP_DIV) && b_zero && !a_zero && !a_inf &&
        !a_snan && !a_qnan)
      det[`FPEX_Z] = 1'b1;
    if (arith_res && !det[`FPEX_V] && !det[`FPEX_Z]) begin
      // overflow also signals inexact, both kept
      if (res_overflow) begin
        det[`FPEX_O] = 1'b1;
        det[`FPEX_I] = 1'b1;
      end
      if (res_inexact)
        det[`FPEX_I] = 1'b1;
      // tiny after rounding and inexact means underflow
      if (res_tiny && res_inexact)
        det[`FPEX_U] = 1'b1;
    end
    // underflow the hardware cannot finish goes to software
    if (det[`FPEX_U] && (enables[`FPEX_U] || enables[`FPEX_I] ||
        !flush_select))
      det[`FPEX_E] = 1'b1;
    else if (det[`FPEX_U])
      det[`FPEX_I] = 1'b1;
    if (op_reserved || op_bad_format)
      det[`FPEX_E] = 1'b1;
    // compares accept quiet NaN and denormal operands
    if (operand_op && !is_cmp && (any_denorm || any_qnan))
      det[`FPEX_E] = 1'b1;
    // trap on any enabled standard type or on unimplemented
    next_trap = det[`FPEX_E] || |(det[4:0] & enables);
    if (det[`FPEX_V])
      next_value = `FPEX_QNAN_D;
    else if (det[`FPEX_Z]) begin
      next_value = `FPEX_INF_D;
      next_value[`FPEX_SIGN_D] = a_neg ^ b_neg;
    end else if (det[`FPEX_O])
      next_value = fpex_round_sub(rnd, res_sign, 1'b1);
    else if (det[`FPEX_U])
      next_value = fpex_round_sub(rnd, res_sign, 1'b0);
    else
      next_value = res_value;
  end

  wire sw_csr_wr = reg_wr && (reg_addr == `FPEX_ADDR_CSR);
  reg [31:0] next_csr;

  // control/status: software write, then hardware sets win over it
  always @* begin
    next_csr = csr;
    if (sw_csr_wr)
      next_csr = reg_wdata & `FPEX_CSR_MASK;
    if (op_valid) begin
      // cause is the latest detections, plus a same-cycle software write
      next_csr[`FPEX_CAUSE_HI:`FPEX_CAUSE_LO] = det |
        (next_csr[`FPEX_CAUSE_HI:`FPEX_CAUSE_LO] &
        {6{sw_csr_wr}});
      if (!next_trap)
        next_csr[`FPEX_FLAG_HI:`FPEX_FLAG_LO] =
          next_csr[`FPEX_FLAG_HI:`FPEX_FLAG_LO] | det[4:0];
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csr <= `FPEX_CSR_RESET;
    end else begin
      csr <= next_csr;
    end
  end

  // result write, trap signalling
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dest_we <= 1'b0;
      dest_value <= `FPEX_ZERO_D;
      trap <= 1'b0;
      trap_code <= 5'h00;
      trap_cause <= 6'h00;
      last_result <= `FPEX_ZERO_D;
    end else begin
      dest_we <= op_valid && !next_trap;
      trap <= op_valid && next_trap;
      if (op_valid && next_trap) begin
        trap_code <= `FPEX_EXC_CODE;
        trap_cause <= det;
      end
      if (op_valid && !next_trap) begin
        dest_value <= next_value;
        last_result <= next_value;
      end
    end
  end

  // read port: data in the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FPEX_ADDR_CSR: reg_rdata <= csr;
        `FPEX_ADDR_STAT: reg_rdata <= {26'h0000000, trap_cause};
        `FPEX_ADDR_RES_LO: reg_rdata <= last_result[31:0];
        `FPEX_ADDR_RES_HI: reg_rdata <= last_result[63:32];
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // fpex_exception_logic

// *** fpex_checker_props.sv ***
// fpex_checker_props.sv: port assertions for the FP exception unit
// assumes binding onto fpex_exception_logic, one clock domain
`timescale 1ns/10ps
`include "fpex_regs.vh"
module fpex_checker (
  input wire clk_sys, rst_n, reg_wr, reg_rd, op_valid,
  input wire op_reserved, op_bad_format, dest_we, trap,
  input wire [3:0] reg_addr, op_class,
  input wire [31:0] reg_wdata, reg_rdata,
  input wire [63:0] dest_value,
  input wire [4:0] trap_code,
  input wire [5:0] trap_cause
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_one_answer: assert property (
    op_valid |=> dest_we != trap) else $error("op not answered once");
  chk_trap_code: assert property (
    trap |-> trap_code == `FPEX_EXC_CODE) else $error("bad trap code");
  chk_trap_reason: assert property (
    trap |-> trap_cause != 6'h00) else $error("trap without cause");
  chk_reserved_trap: assert property (
    op_valid && (op_reserved || op_bad_format) |=> trap && trap_cause[5])
    else $error("reserved op not trapped");
  chk_copy_quiet: assert property (
    op_valid && op_class == `FPEX_OP_COPY && !op_reserved && !op_bad_format
    |=> dest_we) else $error("copy trapped");
  chk_dest_held: assert property (
    trap |-> $stable(dest_value)) else $error("trap altered result");
  chk_read_window: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data out of slot");
  chk_csr_echo: assert property (
    reg_wr && reg_addr == 4'h0 && !op_valid ##1 !reg_wr && !op_valid ##1
    reg_rd && reg_addr == 4'h0 |=> reg_rdata == ($past(reg_wdata, 3) &
    `FPEX_CSR_MASK)) else $error("control word not read back");
endmodule // fpex_checker
bind fpex_exception_logic fpex_checker fpex_checker_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .op_valid(op_valid),
  .op_reserved(op_reserved), .op_bad_format(op_bad_format),
  .dest_we(dest_we), .trap(trap), .reg_addr(reg_addr), .op_class(op_class),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dest_value(dest_value),
  .trap_code(trap_code), .trap_cause(trap_cause));

// *** fpex_core_model.sv ***
// fpex_core_model.sv: core side that records the FP exception code
// assumes trap pulses come straight from the exception unit
`timescale 1ns/10ps
module fpex_core_model (
  input wire clk_sys, rst_n, trap,
  input wire [4:0] trap_code,
  output logic [4:0] exc_code
);
  // core cause register moves only on a taken trap
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) exc_code <= 5'h00;
    else if (trap) exc_code <= trap_code;
  end
endmodule // fpex_core_model

// *** fpex_exception_logic_bench.sv ***
// fpex_exception_logic_bench.sv: self-checking bench of the FP exception unit
// assumes the core model and the bound checker are compiled first
`timescale 1ns/10ps
`include "fpex_regs.vh"
module fpex_exception_logic_bench;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, op_valid = 0, bg;
  logic [3:0] reg_addr = 4'h0, op_class = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [19:0] f = 20'h0;
  logic [63:0] res_value = 64'h3FF0000000000001, last = 64'h0;
  // rows: control word, trap expected, op class, operand and result flags
  logic [63:0] tb [18] = '{64'h1080000, 64'h1940000, 64'h1001000,
    64'h1202000, 64'h1200005, 64'h0100010001200005, 64'h0100008001200005,
    64'h8210, 64'h210200, 64'h310400, 64'h308200, 64'h822000, 64'h400800,
    64'h504000, 64'h604000, 64'h904000, 64'h800100, 64'h100100};
  wire [31:0] reg_rdata;
  wire [63:0] dest_value;
  wire [5:0] trap_cause;
  wire [4:0] trap_code, exc_code;
  wire dest_we, trap;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  fpex_exception_logic fpex_exception_logic_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_class(op_class), .op_reserved(f[19]),
    .op_bad_format(f[18]), .op_cmp_ordered(f[17]), .a_zero(f[16]),
    .a_inf(f[15]), .a_snan(f[14]), .a_qnan(f[13]), .a_denorm(f[12]),
    .a_neg(f[11]), .b_zero(f[10]), .b_inf(f[9]), .b_snan(f[8]),
    .b_qnan(f[7]), .b_denorm(f[6]), .b_neg(f[5]), .eff_subtract(f[4]),
    .res_sign(f[3]), .res_inexact(f[2]), .res_overflow(f[1]),
    .res_tiny(f[0]), .res_value(res_value), .dest_we(dest_we),
    .dest_value(dest_value), .trap(trap), .trap_code(trap_code),
    .trap_cause(trap_cause));
  fpex_core_model fpex_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .trap(trap), .trap_code(trap_code), .exc_code(exc_code));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  // trapped ops must leave the last delivered value in place
  task automatic run(input logic [3:0] c, input logic [19:0] ff,
      input logic t, input logic [5:0] cs, input logic [63:0] v);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_class <= c;
    f <= ff;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk(trap, t);
    chk(dest_we, !t);
    chk(trap_cause & cs, cs);
    if (!t) last = v;
    chk(dest_value, last);
  endtask
  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    acc(0, 4'h0, 32'h0);
    acc(0, 4'h5, 32'h0);
    acc(1, 4'h0, 32'hFFFFFFFF);
    acc(0, 4'h0, 32'h0103FFFF);
    acc(1, 4'h0, 32'h0);
    acc(0, 4'h0, 32'h0);
    run(`FPEX_OP_DIV, 20'h00C08, 0, 6'h0, 64'hFFF0000000000000);
    acc(0, 4'h0, 32'h00008020);
    acc(1, 4'h0, 32'h00000400);
    run(`FPEX_OP_DIV, 20'h00400, 1, 6'h08, 64'h0);
    chk(trap_cause, 6'h08);
    acc(0, 4'h0, 32'h00008400);
    acc(0, 4'h1, 32'h00000008);
    chk(exc_code, `FPEX_EXC_CODE);
    run(`FPEX_OP_COPY, 20'h04000, 0, 6'h0, res_value);
    run(`FPEX_OP_MOVE, 20'h03000, 0, 6'h0, res_value);
    run(`FPEX_OP_ADD, 20'h00004, 0, 6'h0, res_value);
    acc(0, 4'h0, 32'h00001404);
    acc(0, 4'h2, 32'h00000001);
    acc(0, 4'h3, 32'h3FF00000);
    acc(1, 4'h0, 32'h00000200);
    run(`FPEX_OP_MUL, 20'h00006, 1, 6'h05, 64'h0);
    foreach (tb[i]) begin
      acc(1, 4'h0, tb[i][63:32]);
      run(tb[i][23:20], tb[i][19:0], tb[i][24], {tb[i][24], 5'h0},
        `FPEX_QNAN_D);
    end
    acc(0, 4'h0, 32'h00010040);
    for (int k = 0; k < 16; k++) begin
      bg = (k[1:0] == `FPEX_RP && !k[2]) || (k[1:0] == `FPEX_RMI && k[2]);
      bg = bg || (k[1:0] == `FPEX_RN);
      acc(1, 4'h0, 32'h01000000 | k[1:0]);
      run(`FPEX_OP_MUL, {16'h0, k[2], 1'b1, !k[3], k[3]}, 0, 6'h0,
        {k[2], 63'h0} | (k[3] ? (bg ? `FPEX_MINN_D : `FPEX_ZERO_D) :
        (bg ? `FPEX_INF_D : `FPEX_MAXF_D)));
      acc(0, 4'h0, (k[3] ? 32'h0100300C : 32'h01005014) | k[1:0]);
    end
    final_report();
  end
endmodule // fpex_exception_logic_bench
